// file: verilog/eeestp_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: writing one to control bit 15 clears pcs space, then bit self-clears.
// RULE2: soft clear leaves vendor registers, the dsp step words, untouched.
// RULE3: control bit 10, default zero, permits stopping receive clock in idle.
// RULE4: status bit 11 latches one once transmit side saw low-power idle.
// RULE5: status bit 10 latches one once receive side saw low-power idle.
// RULE6: status bit 9 shows live transmit low-power idle.
// RULE7: status bit 8 shows live receive low-power idle.
// RULE8: status bit 6 reads one; status resets to 0x40.
// RULE9: step two word fields, defaults 0x2f1, top six bits read zero.
// RULE10: step three word same layout, default 0x171.
// RULE11: step four word same as step three, at next address.
// RULE12: capability register reads 0x2.
// RULE13: capability bit 1 one for fast rate, bit 2 zero.
// RULE14: soft clear also zeroes the wake fault counter.
// RULE15: step fields go to the receive dsp unchanged.
// RULE16: reserved bits ignore writes and read zero.
module eeestp_regs
  import eeestp_pkg::*;
(
  input  wire logic                      CLK_SYS,
  input  wire logic                      RESETN,
  input  wire logic                      CE,
  input  wire logic [eeestp_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic                      REG_WR,
  input  wire logic [eeestp_pkg::DATA_W-1:0] REG_WDATA,
  input  wire logic                      REG_RD,
  output logic      [eeestp_pkg::DATA_W-1:0] REG_RDATA,
  output logic                           REG_RVALID,
  input  wire logic                      TX_LPI_ACTIVE,
  input  wire logic                      RX_LPI_ACTIVE,
  input  wire logic                      WAKE_FAULT,
  output logic                           RX_CLK_STOP_OK,
  output logic                           PCS_SOFT_CLEAR,
  output logic      [2:0]                STEP_TWO_PROP_GAIN,
  output logic      [2:0]                STEP_TWO_FREQ_GAIN,
  output logic      [1:0]                STEP_TWO_ERR_EST,
  output logic                           STEP_TWO_EQUALIZER,
  output logic                           STEP_TWO_GAIN_CTRL,
  output logic      [2:0]                STEP_THREE_PROP_GAIN,
  output logic      [2:0]                STEP_THREE_FREQ_GAIN,
  output logic      [1:0]                STEP_THREE_ERR_EST,
  output logic                           STEP_THREE_EQUALIZER,
  output logic                           STEP_THREE_GAIN_CTRL,
  output logic      [2:0]                STEP_FOUR_PROP_GAIN,
  output logic      [2:0]                STEP_FOUR_FREQ_GAIN,
  output logic      [1:0]                STEP_FOUR_ERR_EST,
  output logic                           STEP_FOUR_EQUALIZER,
  output logic                           STEP_FOUR_GAIN_CTRL
);
  import eeestp_pkg::*;

  typedef struct packed {
    logic              clk_stop_ok;
    logic              soft_pend;
    logic              tx_lpi_seen;
    logic              rx_lpi_seen;
    logic              tx_lpi_now;
    logic              rx_lpi_now;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
  } eeestp_top_s;

  eeestp_top_s st_reg;
  eeestp_top_s st_next;

  logic [STEP_W-1:0] step_two;
  logic [STEP_W-1:0] step_three;
  logic [STEP_W-1:0] step_four;
  logic [DATA_W-1:0] wake_count;
  logic              wr_two;
  logic              wr_three;
  logic              wr_four;
  logic              wr_ctrl;
  logic              rd_stat;
  logic              rd_wake;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [DATA_W-1:0] step_word(input logic [STEP_W-1:0] w);
    step_word = {{(DATA_W-STEP_W){1'b0}}, w};
  endfunction

  assign wr_two   = REG_WR && hit(REG_ADDR, OFS_STEP_TWO);
  assign wr_three = REG_WR && hit(REG_ADDR, OFS_STEP_THREE);
  assign wr_four  = REG_WR && hit(REG_ADDR, OFS_STEP_FOUR);
  assign wr_ctrl  = REG_WR && hit(REG_ADDR, OFS_PCS_CTRL);
  assign rd_stat  = REG_RD && hit(REG_ADDR, OFS_PCS_STAT);
  assign rd_wake  = REG_RD && hit(REG_ADDR, OFS_WAKE_CNT);

  // RULE2: no soft clear input
  // RULE9: step two word
  eeestp_step_cfg #(.RESET_VAL(RST_STEP_TWO)) u_step_two (
    .clk    (CLK_SYS),
    .resetn (RESETN),
    .ce     (CE),
    .wr_en  (wr_two),
    .wdata  (REG_WDATA[STEP_W-1:0]),
    .word   (step_two)
  );

  // RULE10: step three word
  eeestp_step_cfg #(.RESET_VAL(RST_STEP_THREE)) u_step_three (
    .clk    (CLK_SYS),
    .resetn (RESETN),
    .ce     (CE),
    .wr_en  (wr_three),
    .wdata  (REG_WDATA[STEP_W-1:0]),
    .word   (step_three)
  );

  // RULE11: step four word, next address
  eeestp_step_cfg #(.RESET_VAL(RST_STEP_FOUR)) u_step_four (
    .clk    (CLK_SYS),
    .resetn (RESETN),
    .ce     (CE),
    .wr_en  (wr_four),
    .wdata  (REG_WDATA[STEP_W-1:0]),
    .word   (step_four)
  );

  // RULE14: counter cleared by soft clear
  eeestp_wake_cnt #(.CNT_W(DATA_W)) u_wake_cnt (
    .clk      (CLK_SYS),
    .resetn   (RESETN),
    .ce       (CE),
    .inc      (WAKE_FAULT),
    .rd_clr   (rd_wake),
    .soft_clr (st_reg.soft_pend),
    .count    (wake_count)
  );

  always_comb begin
    st_next        = st_reg;
    st_next.rvalid = REG_RD;
    st_next.rdata  = '0;
    // RULE6: live transmit idle
    st_next.tx_lpi_now = TX_LPI_ACTIVE;
    // RULE7: live receive idle
    st_next.rx_lpi_now = RX_LPI_ACTIVE;
    // RULE4: latched, read clears, new event wins
    st_next.tx_lpi_seen = (st_reg.tx_lpi_seen && !rd_stat) || st_reg.tx_lpi_now;
    // RULE5: latched, read clears, new event wins
    st_next.rx_lpi_seen = (st_reg.rx_lpi_seen && !rd_stat) || st_reg.rx_lpi_now;
    // RULE3: clock stop permission bit
    if (wr_ctrl) begin
      st_next.clk_stop_ok = REG_WDATA[POS_RX_CLK_STOP];
    end
    // RULE1: soft clear request, self-clearing
    st_next.soft_pend = wr_ctrl && REG_WDATA[POS_SOFT_CLEAR];
    if (st_reg.soft_pend) begin
      st_next.clk_stop_ok = RST_PCS_CTRL[POS_RX_CLK_STOP];
      st_next.tx_lpi_seen = RST_PCS_STAT[POS_TX_LPI_SEEN];
      st_next.rx_lpi_seen = RST_PCS_STAT[POS_RX_LPI_SEEN];
    end
    // RULE16: reserved bits read zero
    if (REG_RD) begin
      case (REG_ADDR)
        // RULE15: step words read back as stored
        OFS_STEP_TWO:   st_next.rdata = step_word(step_two);
        OFS_STEP_THREE: st_next.rdata = step_word(step_three);
        OFS_STEP_FOUR:  st_next.rdata = step_word(step_four);
        OFS_PCS_CTRL: begin
          st_next.rdata[POS_SOFT_CLEAR]  = st_reg.soft_pend;
          st_next.rdata[POS_RX_CLK_STOP] = st_reg.clk_stop_ok;
        end
        OFS_PCS_STAT: begin
          st_next.rdata[POS_TX_LPI_SEEN] = st_reg.tx_lpi_seen;
          st_next.rdata[POS_RX_LPI_SEEN] = st_reg.rx_lpi_seen;
          st_next.rdata[POS_TX_LPI_NOW]  = st_reg.tx_lpi_now;
          st_next.rdata[POS_RX_LPI_NOW]  = st_reg.rx_lpi_now;
          // RULE8: mac may stop tx clock
          st_next.rdata[POS_TX_CLK_STOP] = RST_PCS_STAT[POS_TX_CLK_STOP];
        end
        // RULE12: fixed capability value
        // RULE13: fast rate supported, gigabit not
        OFS_EEE_CAP:  st_next.rdata = VAL_EEE_CAP;
        OFS_WAKE_CNT: st_next.rdata = wake_count;
        default:      st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      st_reg.clk_stop_ok <= RST_PCS_CTRL[POS_RX_CLK_STOP];
      st_reg.soft_pend   <= 1'b0;
      st_reg.tx_lpi_seen <= RST_PCS_STAT[POS_TX_LPI_SEEN];
      st_reg.rx_lpi_seen <= RST_PCS_STAT[POS_RX_LPI_SEEN];
      st_reg.tx_lpi_now  <= RST_PCS_STAT[POS_TX_LPI_NOW];
      st_reg.rx_lpi_now  <= RST_PCS_STAT[POS_RX_LPI_NOW];
      st_reg.rdata       <= '0;
      st_reg.rvalid      <= 1'b0;
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  assign REG_RDATA      = st_reg.rdata;
  assign REG_RVALID     = st_reg.rvalid;
  assign RX_CLK_STOP_OK = st_reg.clk_stop_ok;
  // RULE1: pulse clears the rest of the pcs space
  assign PCS_SOFT_CLEAR = st_reg.soft_pend;

  // RULE15: opaque fields to the dsp
  assign STEP_TWO_PROP_GAIN   = step_two[POS_PROP_HI:POS_PROP_LO];
  assign STEP_TWO_FREQ_GAIN   = step_two[POS_FREQ_HI:POS_FREQ_LO];
  assign STEP_TWO_ERR_EST     = step_two[POS_ERR_HI:POS_ERR_LO];
  assign STEP_TWO_EQUALIZER   = step_two[POS_EQU];
  assign STEP_TWO_GAIN_CTRL   = step_two[POS_GAIN];
  assign STEP_THREE_PROP_GAIN = step_three[POS_PROP_HI:POS_PROP_LO];
  assign STEP_THREE_FREQ_GAIN = step_three[POS_FREQ_HI:POS_FREQ_LO];
  assign STEP_THREE_ERR_EST   = step_three[POS_ERR_HI:POS_ERR_LO];
  assign STEP_THREE_EQUALIZER = step_three[POS_EQU];
  assign STEP_THREE_GAIN_CTRL = step_three[POS_GAIN];
  assign STEP_FOUR_PROP_GAIN  = step_four[POS_PROP_HI:POS_PROP_LO];
  assign STEP_FOUR_FREQ_GAIN  = step_four[POS_FREQ_HI:POS_FREQ_LO];
  assign STEP_FOUR_ERR_EST    = step_four[POS_ERR_HI:POS_ERR_LO];
  assign STEP_FOUR_EQUALIZER  = step_four[POS_EQU];
  assign STEP_FOUR_GAIN_CTRL  = step_four[POS_GAIN];
endmodule
`default_nettype wire

// file: verilog/eeestp_pkg.sv
package eeestp_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned STEP_W = 10;

  // register offsets
  localparam logic [15:0] OFS_STEP_TWO   = 16'h04d5;
  localparam logic [15:0] OFS_STEP_THREE = 16'h04d6;
  localparam logic [15:0] OFS_STEP_FOUR  = 16'h04d7;
  localparam logic [15:0] OFS_PCS_CTRL   = 16'h1000;
  localparam logic [15:0] OFS_PCS_STAT   = 16'h1001;
  localparam logic [15:0] OFS_EEE_CAP    = 16'h1014;
  localparam logic [15:0] OFS_WAKE_CNT   = 16'h1016;

  // reset values
  localparam logic [9:0]  RST_STEP_TWO   = 10'h2f1;
  localparam logic [9:0]  RST_STEP_THREE = 10'h171;
  localparam logic [9:0]  RST_STEP_FOUR  = 10'h171;
  localparam logic [15:0] RST_PCS_CTRL   = 16'h0000;
  localparam logic [15:0] RST_PCS_STAT   = 16'h0040;
  localparam logic [15:0] VAL_EEE_CAP    = 16'h0002;
  localparam logic [15:0] RST_WAKE_CNT   = 16'h0000;

  // step word field positions
  localparam int unsigned POS_PROP_HI = 9;
  localparam int unsigned POS_PROP_LO = 7;
  localparam int unsigned POS_FREQ_HI = 6;
  localparam int unsigned POS_FREQ_LO = 4;
  localparam int unsigned POS_ERR_HI  = 3;
  localparam int unsigned POS_ERR_LO  = 2;
  localparam int unsigned POS_EQU     = 1;
  localparam int unsigned POS_GAIN    = 0;

  // pcs control / status bit positions
  localparam int unsigned POS_SOFT_CLEAR  = 15;
  localparam int unsigned POS_RX_CLK_STOP = 10;
  localparam int unsigned POS_TX_LPI_SEEN = 11;
  localparam int unsigned POS_RX_LPI_SEEN = 10;
  localparam int unsigned POS_TX_LPI_NOW  = 9;
  localparam int unsigned POS_RX_LPI_NOW  = 8;
  localparam int unsigned POS_TX_CLK_STOP = 6;
endpackage

// file: verilog/eeestp_step_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module eeestp_step_cfg #(
  parameter logic [9:0] RESET_VAL = 10'h000
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       wr_en,
  input  wire logic [9:0] wdata,
  output logic      [9:0] word
);
  typedef struct packed {
    logic [9:0] word;
  } eeestp_step_s;

  eeestp_step_s st_reg;
  eeestp_step_s st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.word = wdata;
    end
  end

  // pcs soft clear is not wired here: vendor space keeps its value
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg.word <= RESET_VAL;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign word = st_reg.word;
endmodule
`default_nettype wire

// file: verilog/eeestp_wake_cnt.sv
`timescale 1ns/1ps
`default_nettype none
module eeestp_wake_cnt #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic             inc,
  input  wire logic             rd_clr,
  input  wire logic             soft_clr,
  output logic      [CNT_W-1:0] count
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
  } eeestp_cnt_s;

  eeestp_cnt_s st_reg;
  eeestp_cnt_s st_next;

  always_comb begin
    st_next = st_reg;
    if (soft_clr) begin
      st_next.count = '0;
    end else begin
      if (rd_clr) begin
        st_next.count = '0;
      end
      // new fault beats read clear; saturates at all ones
      if (inc && (st_next.count != {CNT_W{1'b1}})) begin
        st_next.count = st_next.count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg.count <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.count;
endmodule
`default_nettype wire

// file: verif/eeestp_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module eeestp_regs_props (
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  input wire logic        CE,
  input wire logic [15:0] REG_ADDR,
  input wire logic        REG_WR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic        REG_RVALID,
  input wire logic        RX_CLK_STOP_OK,
  input wire logic        PCS_SOFT_CLEAR,
  input wire logic [2:0]  STEP_TWO_PROP_GAIN,
  input wire logic [2:0]  STEP_TWO_FREQ_GAIN,
  input wire logic [1:0]  STEP_TWO_ERR_EST,
  input wire logic        STEP_TWO_EQUALIZER,
  input wire logic        STEP_TWO_GAIN_CTRL
);
  import eeestp_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  logic [9:0] two_w;
  logic       wr_ctrl;
  assign two_w = {STEP_TWO_PROP_GAIN, STEP_TWO_FREQ_GAIN, STEP_TWO_ERR_EST,
                  STEP_TWO_EQUALIZER, STEP_TWO_GAIN_CTRL};
  assign wr_ctrl = CE && REG_WR && (REG_ADDR == OFS_PCS_CTRL);
  sequence soft_req;
    wr_ctrl && REG_WDATA[15];
  endsequence
  sequence soft_done;
    PCS_SOFT_CLEAR ##1 (!PCS_SOFT_CLEAR && !RX_CLK_STOP_OK);
  endsequence
  chk_soft_clear_pulse: assert property (soft_req |=> soft_done)
    else $error("soft clear pulse wrong");
  chk_soft_keeps_step: assert property (!(CE && REG_WR) |=> $stable(two_w))
    else $error("step word changed without write");
  chk_stop_write: assert property (
    wr_ctrl && !REG_WDATA[15] |=> RX_CLK_STOP_OK == $past(REG_WDATA[10]))
    else $error("clock stop bit not written");
  chk_stop_hold: assert property (
    !wr_ctrl && !PCS_SOFT_CLEAR |=> $stable(RX_CLK_STOP_OK))
    else $error("clock stop bit changed");
  chk_status_fixed: assert property (
    CE && REG_RD && REG_ADDR == OFS_PCS_STAT |=> REG_RDATA[6] && REG_RDATA[15:12] == 4'h0
    && REG_RDATA[7] == 1'b0 && REG_RDATA[5:0] == 6'h00)
    else $error("status fixed bits wrong");
  chk_cap_value: assert property (
    CE && REG_RD && REG_ADDR == OFS_EEE_CAP |=> REG_RDATA == 16'h0002)
    else $error("capability value wrong");
  chk_two_write: assert property (
    CE && REG_WR && REG_ADDR == OFS_STEP_TWO |=> two_w == $past(REG_WDATA[9:0]))
    else $error("step two fields wrong");
  chk_read_answer: assert property (CE && REG_RD |=> REG_RVALID)
    else $error("read answer missing");
  chk_read_quiet: assert property (CE && !REG_RD |=> !REG_RVALID)
    else $error("read answer without read");
  chk_rdata_idle: assert property (!REG_RVALID |-> REG_RDATA == 16'h0000)
    else $error("read data not zero");
endmodule
bind eeestp_regs eeestp_regs_props eeestp_regs_props_i (.CLK_SYS, .RESETN, .CE, .REG_ADDR,
  .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA, .REG_RVALID, .RX_CLK_STOP_OK, .PCS_SOFT_CLEAR,
  .STEP_TWO_PROP_GAIN, .STEP_TWO_FREQ_GAIN, .STEP_TWO_ERR_EST, .STEP_TWO_EQUALIZER,
  .STEP_TWO_GAIN_CTRL);
`default_nettype wire

// file: verif/eeestp_mgmt_model.sv
`timescale 1ns/1ps
`default_nettype none
module eeestp_mgmt_model (
  input  wire logic        clk,
  output logic      [15:0] addr,
  output logic             wr,
  output logic      [15:0] wdata,
  output logic             rd,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid
);
  import eeestp_pkg::*;
  initial begin
    addr = 16'h0000;
    wr = 1'b0;
    wdata = 16'h0000;
    rd = 1'b0;
  end
  // idle bus shows the inverse of the last value
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d, output logic v);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    d = rdata;
    v = rvalid;
  endtask
endmodule
`default_nettype wire

// file: verif/eeestp_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eeestp_regs_tb;
  import eeestp_pkg::*;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic        tx_lpi = 1'b0;
  logic        rx_lpi = 1'b0;
  logic        wake_fault = 1'b0;
  wire  [15:0] addr, wdata, rdata;
  wire         wr, rd, rvalid, stop_ok, soft_clear;
  wire  [9:0]  s2, s3, s4;
  int          miscompares = 0;
  int          compares = 0;
  always #25 clk_sys = ~clk_sys;
  eeestp_mgmt_model eeestp_mgmt_model_i (.clk(clk_sys), .addr(addr), .wr(wr), .wdata(wdata),
    .rd(rd), .rdata(rdata), .rvalid(rvalid));
  eeestp_regs eeestp_regs_i (.CLK_SYS(clk_sys), .RESETN(resetn), .CE(ce), .REG_ADDR(addr),
    .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .TX_LPI_ACTIVE(tx_lpi), .RX_LPI_ACTIVE(rx_lpi), .WAKE_FAULT(wake_fault),
    .RX_CLK_STOP_OK(stop_ok), .PCS_SOFT_CLEAR(soft_clear),
    .STEP_TWO_PROP_GAIN(s2[9:7]), .STEP_TWO_FREQ_GAIN(s2[6:4]), .STEP_TWO_ERR_EST(s2[3:2]),
    .STEP_TWO_EQUALIZER(s2[1]), .STEP_TWO_GAIN_CTRL(s2[0]),
    .STEP_THREE_PROP_GAIN(s3[9:7]), .STEP_THREE_FREQ_GAIN(s3[6:4]),
    .STEP_THREE_ERR_EST(s3[3:2]), .STEP_THREE_EQUALIZER(s3[1]), .STEP_THREE_GAIN_CTRL(s3[0]),
    .STEP_FOUR_PROP_GAIN(s4[9:7]), .STEP_FOUR_FREQ_GAIN(s4[6:4]), .STEP_FOUR_ERR_EST(s4[3:2]),
    .STEP_FOUR_EQUALIZER(s4[1]), .STEP_FOUR_GAIN_CTRL(s4[0]));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    eeestp_mgmt_model_i.rd_reg(a, d, v);
    check({15'h0000, v}, 16'h0001);
    check(d, exp);
  endtask
  task automatic test_defaults;
    logic [15:0] a [8] = '{16'h04d5, 16'h04d6, 16'h04d7, 16'h1000, 16'h1001, 16'h1014,
                           16'h1016, 16'h1002};
    logic [15:0] e [8] = '{16'h02f1, 16'h0171, 16'h0171, 16'h0000, 16'h0040, 16'h0002,
                           16'h0000, 16'h0000};
    check({6'h00, s2}, 16'h02f1);
    check({6'h00, s3}, 16'h0171);
    check({6'h00, s4}, 16'h0171);
    check({15'h0000, stop_ok}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      rd_chk(a[i], e[i]);
    end
    for (int i = 4; i < 8; i++) begin
      eeestp_mgmt_model_i.wr_reg(a[i], 16'hffff);
      rd_chk(a[i], e[i]);
    end
  endtask
  task automatic test_steps;
    logic [15:0] a [3] = '{16'h04d5, 16'h04d6, 16'h04d7};
    for (int i = 0; i < 3; i++) begin
      eeestp_mgmt_model_i.wr_reg(a[i], 16'hffff);
      rd_chk(a[i], 16'h03ff);
      eeestp_mgmt_model_i.wr_reg(a[i], 16'h0150 | 16'(i));
    end
    check({6'h00, s2}, 16'h0150);
    check({6'h00, s3}, 16'h0151);
    check({6'h00, s4}, 16'h0152);
  endtask
  task automatic test_freeze;
    @(negedge clk_sys);
    ce = 1'b0;
    eeestp_mgmt_model_i.wr_reg(16'h04d5, 16'h0000);
    check({6'h00, s2}, 16'h0150);
    ce = 1'b1;
    rd_chk(16'h04d5, 16'h0150);
  endtask
  task automatic test_lpi;
    logic [15:0] now;
    for (int s = 0; s < 2; s++) begin
      now = (s == 0) ? 16'h0200 : 16'h0100;
      {tx_lpi, rx_lpi} = (s == 0) ? 2'b10 : 2'b01;
      repeat (3) @(negedge clk_sys);
      rd_chk(16'h1001, 16'h0040 | now | (now << 2));
      rd_chk(16'h1001, 16'h0040 | now | (now << 2));
      {tx_lpi, rx_lpi} = 2'b00;
      repeat (3) @(negedge clk_sys);
      rd_chk(16'h1001, 16'h0040 | (now << 2));
      rd_chk(16'h1001, 16'h0040);
    end
  endtask
  task automatic test_soft_clear;
    eeestp_mgmt_model_i.wr_reg(16'h1000, 16'h7fff);
    check({15'h0000, stop_ok}, 16'h0001);
    rd_chk(16'h1000, 16'h0400);
    rx_lpi = 1'b1;
    repeat (2) begin
      @(negedge clk_sys);
      wake_fault = 1'b1;
      @(negedge clk_sys);
      wake_fault = 1'b0;
    end
    rx_lpi = 1'b0;
    rd_chk(16'h1016, 16'h0002);
    rd_chk(16'h1016, 16'h0000);
    wake_fault = 1'b1;
    @(negedge clk_sys);
    wake_fault = 1'b0;
    eeestp_mgmt_model_i.wr_reg(16'h1000, 16'h8400);
    check({15'h0000, soft_clear}, 16'h0001);
    @(negedge clk_sys);
    check({14'h0000, soft_clear, stop_ok}, 16'h0000);
    rd_chk(16'h1000, 16'h0000);
    rd_chk(16'h1001, 16'h0040);
    rd_chk(16'h1016, 16'h0000);
    rd_chk(16'h04d5, 16'h0150);
    check({6'h00, s4}, 16'h0152);
  endtask
  task automatic print_verdict;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    test_defaults();
    test_steps();
    test_freeze();
    test_lpi();
    test_soft_clear();
    print_verdict();
  end
  initial begin
    #50000;
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
